// file: logic/rcal_top.sv
`timescale 1ns/1ps
// ****************************************
// calendar time and date registers
// ****************************************
module rcal_top
  import rcal_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] time_word,
  output logic [31:0] date_word
);

  // ****************************************
  // bcd helpers
  // ****************************************

  // two-digit bcd increment, caller handles wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // leap test valid for two-digit years in one century
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  // last day of a month, all in bcd
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic leap);
    case (m)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  // ****************************************
  // state
  // ****************************************
  logic [31:0] time_r; // calendar_time
  logic [31:0] time_nxt;
  logic [31:0] date_r; // calendar_date
  logic [31:0] date_nxt;
  logic [31:0] ctrl_r; // run and hour format
  logic tick; // one-second enable
  logic acc; // apb access phase
  logic commit; // transfer completes this edge
  logic wr_time; // software write of time
  logic wr_date; // software write of date
  logic wr_ctrl; // software write of control
  logic mapped; // address hits a register

  // ****************************************
  // apb decode
  // ****************************************

  // one wait state: pready rises in the second access cycle
  assign acc = psel && penable;
  assign commit = acc && pready;
  assign mapped = (paddr == ADDR_TIME) || (paddr == ADDR_DATE) ||
                  (paddr == ADDR_CTRL);
  assign wr_time = commit && pwrite && (paddr == ADDR_TIME);
  assign wr_date = commit && pwrite && (paddr == ADDR_DATE);
  assign wr_ctrl = commit && pwrite && (paddr == ADDR_CTRL);

  // ready pulse, one cycle per transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= acc && !pready;
    end
  end

  // error answer for unmapped or misaligned addresses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc && !pready && !mapped;
    end
  end

  // read data captured with pready, reserved bits read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (acc && !pready && !pwrite) begin
      case (paddr)
        ADDR_TIME: prdata <= time_r;
        ADDR_DATE: prdata <= date_r;
        ADDR_CTRL: prdata <= ctrl_r;
        default: prdata <= '0; // unmapped reads zero
      endcase
    end else begin
      prdata <= '0;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  // ****************************************
  // second divider
  // ****************************************

  // a time write restarts the second so it holds a full period
  rcal_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .run(ctrl_r[CTRL_RUN_BIT]),
    .clr(wr_time),
    .tick(tick)
  );

  // ****************************************
  // calendar advance
  // ****************************************
  always_comb begin
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] yr;
    logic [2:0] wd;
    logic pm;
    logic c_min;
    logic c_hr;
    logic c_day;
    logic c_mon;
    logic c_yr;
    sec = {1'b0, time_r[SEC_LSB +: 7]};
    min = {1'b0, time_r[MIN_LSB +: 7]};
    hr = {2'b00, time_r[HOUR_LSB +: 6]};
    pm = time_r[TIME_PM_BIT];
    day = {2'b00, date_r[DAY_LSB +: 6]};
    mon = {3'b000, date_r[MON_LSB +: 5]};
    yr = date_r[YEAR_LSB +: 8];
    wd = date_r[WDAY_LSB +: 3];
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_yr = 1'b0;
    // seconds roll into minutes
    if (tick) begin
      if (sec == BCD_LAST_SEC) begin
        sec = 8'h00;
        c_min = 1'b1;
      end else begin
        sec = bcd_inc(sec);
      end
    end
    // minutes roll into hours
    if (c_min) begin
      if (min == BCD_LAST_SEC) begin
        min = 8'h00;
        c_hr = 1'b1;
      end else begin
        min = bcd_inc(min);
      end
    end
    // hours: 24h wraps at 23, 12h runs 12,01..11
    if (c_hr) begin
      if (!ctrl_r[CTRL_H12_BIT]) begin
        pm = 1'b0;
        if (hr == BCD_LAST_H24) begin
          hr = 8'h00;
          c_day = 1'b1;
        end else begin
          hr = bcd_inc(hr);
        end
      end else if (hr == BCD_H12_ELEVEN) begin
        hr = BCD_H12_TWELVE;
        c_day = pm; // 11 pm to 12 am is midnight
        pm = !pm;
      end else if (hr == BCD_H12_TWELVE) begin
        hr = BCD_ONE;
      end else begin
        hr = bcd_inc(hr);
      end
    end
    // day and weekday move together
    if (c_day) begin
      if (day == last_day(mon, is_leap(yr))) begin
        day = BCD_ONE;
        c_mon = 1'b1;
      end else begin
        day = bcd_inc(day);
      end
      wd = (wd == WDAY_SUN) ? WDAY_MON : wd + 3'h1;
    end
    // months wrap at twelve
    if (c_mon) begin
      if (mon == BCD_LAST_MON) begin
        mon = BCD_ONE;
        c_yr = 1'b1;
      end else begin
        mon = bcd_inc(mon);
      end
    end
    // years wrap at 99
    if (c_yr) begin
      yr = (yr == BCD_LAST_YEAR) ? 8'h00 : bcd_inc(yr);
    end
    // repack, unused positions forced to zero
    time_nxt = '0;
    time_nxt[TIME_PM_BIT] = pm;
    time_nxt[HOUR_LSB +: 6] = hr[5:0];
    time_nxt[MIN_LSB +: 7] = min[6:0];
    time_nxt[SEC_LSB +: 7] = sec[6:0];
    date_nxt = '0;
    date_nxt[YEAR_LSB +: 8] = yr;
    date_nxt[WDAY_LSB +: 3] = wd;
    date_nxt[MON_LSB +: 5] = mon[4:0];
    date_nxt[DAY_LSB +: 6] = day[5:0];
    // software write wins over a tick in the same cycle
    if (wr_time) begin
      time_nxt = pwdata & TIME_MASK;
    end
    if (wr_date) begin
      date_nxt = pwdata & DATE_MASK;
      // forbidden weekday zero keeps the old code
      if (pwdata[WDAY_LSB +: 3] == 3'h0) begin
        date_nxt[WDAY_LSB +: 3] = date_r[WDAY_LSB +: 3];
      end
    end
  end

  // time holding register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_r <= TIME_RST;
    end else begin
      time_r <= time_nxt;
    end
  end

  // date holding register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      date_r <= DATE_RST;
    end else begin
      date_r <= date_nxt;
    end
  end

  // live copies for the rest of the chip
  assign time_word = time_r;
  assign date_word = date_r;

  // ****************************************
  // checks
  // ****************************************

  // hour never leaves 00..23 in bcd
  AST_HOUR_RANGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !wr_time |=> (time_r[HOUR_LSB +: 6] <= 6'h23)
  ) else $error("hour out of range");

  // minute tens stays within 0..5
  AST_MIN_RANGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    $past(tick) && !$past(wr_time) && ($past(time_r[14:12]) <= 3'h5)
    |-> (time_r[14:12] <= 3'h5)
  ) else $error("minute tens out of range");

  // second wrap clears the seconds and moves the minute
  AST_SEC_WRAP: assert property (
    @(posedge clk) disable iff (!arst_n)
    tick && !wr_time && (time_r[6:0] == 7'h59)
    |=> (time_r[6:0] == 7'h00) && (time_r[14:8] != $past(time_r[14:8]))
  ) else $error("second wrap wrong");

  // pm flag cleared by an hour carry in 24-hour mode; a write may set it
  AST_PM_24H: assert property (
    @(posedge clk) disable iff (!arst_n)
    tick && !wr_time && !ctrl_r[CTRL_H12_BIT] &&
    (time_r[14:0] == 15'h5959) |=> !time_r[TIME_PM_BIT]
  ) else $error("pm flag set in 24h mode");

  // year steps only when the month wraps from december
  AST_YEAR_STEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    !$past(wr_date) && (date_r[23:16] != $past(date_r[23:16]))
    |-> $past(date_r[12:8]) == 5'h12
  ) else $error("year moved without december wrap");

  // weekday code never zero
  AST_WDAY_NONZERO: assert property (
    @(posedge clk) disable iff (!arst_n)
    date_r[WDAY_LSB +: 3] != 3'h0
  ) else $error("weekday code zero");

  // month held within 01..12
  AST_MONTH_RANGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !wr_date |=> (date_r[12:8] >= 5'h01) && (date_r[12:8] <= 5'h12)
                 || $past(date_r[12:8]) == 5'h00
  ) else $error("month out of range");

  // day units never beyond nine
  AST_DAY_BCD: assert property (
    @(posedge clk) disable iff (!arst_n)
    tick && !wr_date |=> date_r[3:0] <= 4'h9 || $past(date_r[3:0]) > 4'h9
  ) else $error("day units not bcd");

  // unused positions read zero after any update
  AST_RSVD_ZERO: assert property (
    @(posedge clk) disable iff (!arst_n)
    ((time_r & ~TIME_MASK) == '0) && ((date_r & ~DATE_MASK) == '0)
  ) else $error("reserved bits set");

  // read of the time word returns it one cycle later
  AST_READ_TIME: assert property (
    @(posedge clk) disable iff (!arst_n)
    acc && !pready && !pwrite && (paddr == ADDR_TIME)
    |=> pready && (prdata == $past(time_r))
  ) else $error("time read mismatch");

endmodule : rcal_top

// file: include/rcal_pkg.sv
package rcal_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_TIME = 8'h00; // calendar_time
  localparam logic [7:0] ADDR_DATE = 8'h04; // calendar_date
  localparam logic [7:0] ADDR_CTRL = 8'h08; // run / hour format

  // reset values
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] DATE_RST = 32'h00002101;
  localparam logic [31:0] CTRL_RST = 32'h00000001;

  // writable bit masks, unused positions stay zero
  localparam logic [31:0] TIME_MASK = 32'h007F7F7F;
  localparam logic [31:0] DATE_MASK = 32'h00FFFF3F;
  localparam logic [31:0] CTRL_MASK = 32'h00000003;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TIME_PM_BIT = 22; // pm_flag
  localparam int HOUR_LSB = 16; // hour_units, hour_tens above
  localparam int MIN_LSB = 8; // minute_units, minute_tens above
  localparam int SEC_LSB = 0; // second_units, second_tens above
  localparam int YEAR_LSB = 16; // year_units, year_tens above
  localparam int WDAY_LSB = 13; // weekday_code
  localparam int MON_LSB = 8; // month_units, month_tens above
  localparam int DAY_LSB = 0; // day_units, day_tens above
  localparam int CTRL_RUN_BIT = 0; // calendar counts when set
  localparam int CTRL_H12_BIT = 1; // 12-hour format when set

  // calendar limits in packed bcd
  localparam logic [2:0] WDAY_MON = 3'h1;
  localparam logic [2:0] WDAY_SUN = 3'h7;
  localparam logic [7:0] BCD_LAST_SEC = 8'h59;
  localparam logic [7:0] BCD_LAST_H24 = 8'h23;
  localparam logic [7:0] BCD_H12_ELEVEN = 8'h11;
  localparam logic [7:0] BCD_H12_TWELVE = 8'h12;
  localparam logic [7:0] BCD_LAST_MON = 8'h12;
  localparam logic [7:0] BCD_LAST_YEAR = 8'h99;
  localparam logic [7:0] BCD_ONE = 8'h01;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 20000000; // 50 ns period
  localparam int TICK_PERIOD_MS = 1000; // one calendar second
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_PERIOD_MS;

endpackage : rcal_pkg

// file: logic/rcal_tick.sv
`timescale 1ns/1ps
// ****************************************
// one-second enable divider
// ****************************************
module rcal_tick
  import rcal_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic clr,
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r; // cycles into current second

  // counter restarts on clear so a fresh time starts a full second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (clr || !run) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // one-cycle pulse at the end of each second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !clr && (cnt_r == LAST);
    end
  end

endmodule : rcal_tick

// file: verification/tb_rtc_calendar_time_date_regs.sv
`timescale 1ns/1ps
module tb_rtc_calendar_time_date_regs
  import rcal_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  localparam int TCYC = 10; // short calendar second keeps the run brief
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, time_word, date_word;
  logic [31:0] tv, dv;
  logic [7:0] hv, mv, sv, yv, mov, dyv; // random bcd fields
  logic [3:0] r4; // random nibble for the meridiem bit
  logic [32:0] note_e; // oldest note: {pslverr, prdata}
  logic [32:0] notes[$]; // expected answers in issue order
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 66081;
  // rows: control, time in, date in, time out, date out
  logic [31:0] rows [6][5] = '{
    '{32'h1, 32'h00000959, 32'h00002101, 32'h00001000, 32'h00002101},
    '{32'h1, 32'h00495959, 32'h00002101, 32'h00100000, 32'h00002101},
    '{32'h1, 32'h00235959, 32'h0099F231, 32'h00000000, 32'h00002101},
    '{32'h1, 32'h00235959, 32'h00252228, 32'h00000000, 32'h00254301},
    '{32'h1, 32'h00235959, 32'h00242228, 32'h00000000, 32'h00244229},
    '{32'h3, 32'h00115959, 32'h00002101, 32'h00520000, 32'h00002101}};

  // free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  rcal_top #(.TICK_CYC(TCYC)) i_dut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .time_word(time_word), .date_word(date_word));

  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : check

  // one apb transfer; the expected answer is noted before it starts
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    int n;
    notes.push_back({err, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(negedge clk);
    // wait bounded: no fixed latency is assumed
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        $display("[ERR] pready exp 1 got %b", pready);
        stop_test();
      end
      @(negedge clk);
    end
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h00000000, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, e, 1'b0);
  endtask : rd

  // waits for the calendar to move, bounded by a few seconds
  task automatic wait_tick;
    logic [31:0] t0;
    int n;
    t0 = time_word;
    n = 0;
    while (time_word === t0) begin
      n++;
      if (n > 4 * TCYC) begin
        miscompares++;
        $display("[ERR] tick exp 1 got 0");
        stop_test();
      end
      @(negedge clk);
    end
  endtask : wait_tick

  function automatic logic [3:0] dig(input int lim);
    dig = 4'($unsigned($random(seed)) % lim);
  endfunction : dig

  // random value lo..lo+n-1 packed as two bcd digits
  function automatic logic [7:0] rnd_bcd(input int lo, input int n);
    int v;
    v = lo + int'($unsigned($random(seed)) % n);
    rnd_bcd = {4'(v / 10), 4'(v % 10)};
  endfunction : rnd_bcd

  // ****************************************
  // monitor: pops the oldest note per answer
  // ****************************************
  always @(negedge clk) begin
    if (arst_n === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("[ERR] note exp 1 got 0");
      end else begin
        note_e = notes.pop_front();
        check("prdata", note_e[31:0], prdata);
        check("pslverr", {31'h0, note_e[32]}, {31'h0, pslverr});
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("time_word", TIME_RST, time_word); // reset value
    check("date_word", DATE_RST, date_word); // reset value
    rd(ADDR_TIME, TIME_RST); // read before first second
    rd(ADDR_DATE, DATE_RST);
    wr(ADDR_CTRL, 32'h00000000); // stop calendar for stable readback
    $display("test reset done");
    // random bcd fields round trip through both words
    for (int i = 0; i < 6; i++) begin
      hv = rnd_bcd(0, 24); // legal calendar values only
      mv = rnd_bcd(0, 60);
      sv = rnd_bcd(0, 60);
      r4 = dig(2);
      tv = {9'h0, r4[0], hv[5:0], 1'b0, mv[6:0], 1'b0, sv[6:0]};
      yv = rnd_bcd(0, 100);
      mov = rnd_bcd(1, 12);
      dyv = rnd_bcd(1, 28);
      dv = {8'h0, yv, 3'(dig(7) + 4'h1), mov[4:0], 2'b00, dyv[5:0]};
      wr(ADDR_TIME, tv); // unused bits kept zero
      wr(ADDR_DATE, dv); // unused bits kept zero
      rd(ADDR_TIME, tv); // field readback
      rd(ADDR_DATE, dv); // field readback
      check("time_word", tv, time_word); // live word
      check("date_word", dv, date_word); // live word
    end
    $display("test fields done");
    // every weekday code, then the forbidden code keeps the old one
    for (int k = 1; k < 8; k++) begin
      dv = {16'h0024, 3'(k), 13'h0515};
      wr(ADDR_DATE, dv);
      rd(ADDR_DATE, dv); // weekday code
    end
    wr(ADDR_DATE, 32'h00251231);
    rd(ADDR_DATE, 32'h0025F231); // zero weekday refused
    $display("test weekday done");
    // unmapped and misaligned places answer with an error
    apb(1'b1, 8'h0C, 32'hFFFFFFFF, 32'h00000000, 1'b1);
    apb(1'b1, 8'h02, 32'h00123456, 32'h00000000, 1'b1);
    apb(1'b0, 8'h40, 32'h00000000, 32'h00000000, 1'b1);
    rd(ADDR_TIME, tv); // time untouched by refused writes
    rd(ADDR_CTRL, 32'h00000000);
    $display("test errors done");
    // calendar carries, run for one second each row
    for (int r = 0; r < 6; r++) begin
      wr(ADDR_TIME, rows[r][1]);
      wr(ADDR_DATE, rows[r][2]);
      wr(ADDR_CTRL, rows[r][0]);
      wait_tick();
      wr(ADDR_CTRL, 32'h00000000); // stop well before the next second
      rd(ADDR_TIME, rows[r][3]); // carry and meridiem
      rd(ADDR_DATE, rows[r][4]); // day, weekday, month, year
    end
    $display("test rollover done");
    repeat (2) @(negedge clk);
    check("notes", 32'h0, 32'(notes.size()));
    stop_test();
  end
endmodule : tb_rtc_calendar_time_date_regs
